// file: core/cgm_consts.svh
// Purpose: Constants of the channel gain and overload monitor
// Assumes: Word addresses, 16-bit register data
// Notes: Channel registers sit at base plus eight words per channel
`ifndef CGM_CONSTS_SVH
`define CGM_CONSTS_SVH
// Register word addresses
`define CGM_REG_CTRL 8'h00
`define CGM_REG_STATUS 8'h01
`define CGM_CH_BASE 8'h10
// Channel field offsets
`define CGM_CH_GAIN 3'h0
`define CGM_CH_EXC 3'h1
`define CGM_CH_SENSOR_SENSITIVITY 3'h2
`define CGM_CH_FULL_SCALE_INPUT_VALUE 3'h3
`define CGM_CH_LEVEL 3'h4
`define CGM_CH_NORM 3'h5
`define CGM_CH_STAT 3'h6
// Field positions
`define CGM_CTRL_SAVE 2
`define CGM_CTRL_DEFAULT 3
`define CGM_EXC_ON_BIT 8
// Factory defaults and top gain for scaling
`define CGM_DEF_GAIN 8'h01
`define CGM_DEF_EXC 8'h28
`define CGM_DEF_EXC_ON 1'b1
`define CGM_DEF_SENSOR_SENSITIVITY 16'h0064
`define CGM_DEF_FULL_SCALE_INPUT_VALUE 16'h000a
`define CGM_DEF_LEVEL 1'b0
`define CGM_GAIN_TOP 8'hff
// Excitation ceiling in 0.1 mA steps, 20 mA
`define CGM_EXC_MAX 8'hc8
// Bias window in mV, 2.0 V and 22 V
`define CGM_SHORT_MV 16'h07d0
`define CGM_OPEN_MV 16'h55f0
// Output level in mV per unit, 1 V and 5 V
`define CGM_LEVEL_1V 16'h03e8
`define CGM_LEVEL_5V 16'h1388
// Timing
`define CGM_CLK_HZ 125000000
`define CGM_BAUD 19200
`define CGM_SETTLE_MS 100
// Line characters
`define CGM_CHR_CR 8'h0d
`define CGM_CHR_LF 8'h0a
`define CGM_CHR_RD 8'h52
`define CGM_CHR_WR 8'h57
`endif

// file: core/cgm_pkg.sv
// Purpose: Types of the channel gain and overload monitor
// Assumes: Nothing
// Notes: One-hot scaling states
package cgm_pkg;
    typedef enum logic [3:0] {
        AS_IDLE = 4'b0001,
        AS_MAX = 4'b0010,
        AS_SETTLE = 4'b0100,
        AS_CHECK = 4'b1000
    } cgm_as_state_t;
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_ON = 2'h1,
        MODE_SINGLE = 2'h2
    } cgm_scale_mode_t;
    typedef struct packed {
        logic [15:0] full_scale_input_value;
        logic [15:0] sensor_sensitivity;
        logic [7:0] gain;
        logic [7:0] exc_level;
        logic exc_on;
        logic full_scale_output_level;
    } cgm_chan_t;
endpackage

// file: core/cgm_monitor.sv
// Purpose: Channel gain, excitation, fault and overload control with serial access
// Assumes: Bias readings arrive in mV on clk_in; comparators and serial are async
// Notes: Serial lines use the register port in its idle cycles
// How it works
// - Excitation current settable per channel, capped at 20 mA.
// - Excitation reaches the input only while the channel's switch is on.
// - Short and open faults detected per channel; either lights the fault lamp.
// - Bias below 2.0 V is short, above 22 V is open.
// - Normalised gain is output level over sensitivity times full-scale input.
// - Output level selectable as 1 V or 5 V per unit.
// - Error flag when the needed gain is too large or too small.
// - Gains and settings kept in non-volatile store, saved at power-down.
// - Scaling start sets every channel to maximum gain.
// - While scaling, overloaded channels step their gain down until none overload.
// - Scaling modes off, on, and single-shot that switches itself off.
// - Gains and overload status readable by the host after scaling.
// - Comparator output idles high and goes low on overload.
// - Low comparator output lights overload lamp and sets the channel latch.
// - Overload latch holds until the host reads the overload status.
// - At power-up every stored setting is restored.
// - Factory reset overwrites the stored configuration with defaults.
// - Serial link 19200 baud, 8 data bits, no parity, one stop bit.
// - Serial lines end in carriage return then line feed.
// - Every setting reachable over the serial link.
`timescale 1ns/1ps
`include "cgm_consts.svh"
module cgm_monitor
    import cgm_pkg::*;
#(
    parameter int NCH = 4,
    parameter int GAIN_MIN = 1,
    parameter int GAIN_MAX = 255,
    parameter int BIT_CYCLES = `CGM_CLK_HZ / `CGM_BAUD,
    parameter int SETTLE_CYCLES = (`CGM_CLK_HZ / 1000) * `CGM_SETTLE_MS
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [7:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    input wire logic [NCH*16-1:0] bias_mv_in,
    input wire logic [NCH-1:0] ovl_cmp_n_in,
    input wire logic power_down_in,
    input wire logic factory_reset_in,
    input wire logic rx_in,
    output logic tx_out,
    output logic [NCH*8-1:0] gain_out,
    output logic [NCH*8-1:0] exc_level_out,
    output logic [NCH-1:0] exc_on_out,
    output logic [NCH-1:0] fault_led_out,
    output logic [NCH-1:0] ovl_led_out,
    output logic scaling_active_out
);
    localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;
    localparam cgm_chan_t CH_DEF = {`CGM_DEF_FULL_SCALE_INPUT_VALUE, `CGM_DEF_SENSOR_SENSITIVITY, `CGM_DEF_GAIN,
                                    `CGM_DEF_EXC, `CGM_DEF_EXC_ON, `CGM_DEF_LEVEL};

    function automatic logic [7:0] cgm_hex_chr(input logic [3:0] n);
        cgm_hex_chr = (n < 4'ha) ? {4'h3, n} : 8'(8'h37 + {4'h0, n});
    endfunction

    cgm_chan_t ch [NCH];
    cgm_chan_t nv [NCH];
    logic [15:0] norm [NCH];
    logic [NCH-1:0] gerr, short_f, open_f, ovl_latch, seen;
    logic [NCH+2:0] sync1, sync2;
    logic pd_d, fr_d, restore_pend;
    bit nv_ok;
    cgm_scale_mode_t mode;
    cgm_as_state_t as_state;
    logic [31:0] as_cnt;

    // Input synchronisers, reset to idle pin levels so no false edge follows reset
    localparam logic [NCH+2:0] SYNC_IDLE = {1'b1, 2'b00, {NCH{1'b1}}};
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            sync1 <= SYNC_IDLE;
            sync2 <= SYNC_IDLE;
            pd_d <= 1'b0;
            fr_d <= 1'b0;
        end else begin
            sync1 <= {rx_in, factory_reset_in, power_down_in, ovl_cmp_n_in};
            sync2 <= sync1;
            pd_d <= sync2[NCH];
            fr_d <= sync2[NCH+1];
        end
    end
    wire rx_s = sync2[NCH+2];
    wire [NCH-1:0] ovl_now = ~sync2[NCH-1:0];
    wire pd_rise = sync2[NCH] & ~pd_d;
    wire fr_rise = sync2[NCH+1] & ~fr_d;

    // Serial receiver, 8N1
    logic [3:0] rx_bit;
    logic [15:0] rx_cnt;
    logic [7:0] rx_sh;
    logic rx_stb;
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            rx_bit <= 4'h0;
            rx_cnt <= 16'h0000;
            rx_sh <= 8'h00;
            rx_stb <= 1'b0;
        end else begin
            rx_stb <= 1'b0;
            if (rx_bit == 4'h0) begin
                if (!rx_s) begin
                    rx_bit <= 4'h1;
                    rx_cnt <= 16'(BIT_CYCLES / 2);
                end
            end else if (rx_cnt != 16'h0000) begin
                rx_cnt <= rx_cnt - 16'h0001;
            end else begin
                rx_cnt <= 16'(BIT_CYCLES - 1);
                if (rx_bit == 4'h1) begin
                    rx_bit <= rx_s ? 4'h0 : 4'h2;
                end else if (rx_bit == 4'ha) begin
                    rx_stb <= rx_s;
                    rx_bit <= 4'h0;
                end else begin
                    rx_sh <= {rx_s, rx_sh[7:1]};
                    rx_bit <= rx_bit + 4'h1;
                end
            end
        end
    end

    // Line parser: R aa or W aa dddd, then CR LF
    logic [7:0] p_cmd;
    logic [23:0] p_acc;
    logic p_cr, ser_pend, s_wr;
    logic [7:0] s_addr;
    logic [15:0] s_data;
    logic [2:0] tx_chars;
    logic [3:0] tx_bit;
    wire tx_idle = (tx_bit == 4'h0) && (tx_chars == 3'h0);
    wire hex_dig = (rx_sh >= 8'h30) && (rx_sh <= 8'h39);
    wire hex_let = ((rx_sh >= 8'h41) && (rx_sh <= 8'h46)) || ((rx_sh >= 8'h61) && (rx_sh <= 8'h66));
    wire [3:0] hex_val = hex_dig ? rx_sh[3:0] : 4'(rx_sh[3:0] + 4'h9);
    wire ser_go = ser_pend && !wr_in && !rd_in;
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            p_cmd <= 8'h00;
            p_acc <= 24'h000000;
            p_cr <= 1'b0;
            ser_pend <= 1'b0;
            s_wr <= 1'b0;
            s_addr <= 8'h00;
            s_data <= 16'h0000;
        end else begin
            if (ser_go) ser_pend <= 1'b0;
            if (rx_stb) begin
                p_cr <= (rx_sh == `CGM_CHR_CR);
                if (rx_sh == `CGM_CHR_RD || rx_sh == `CGM_CHR_WR) begin
                    p_cmd <= rx_sh;
                    p_acc <= 24'h000000;
                end else if (hex_dig || hex_let) begin
                    p_acc <= {p_acc[19:0], hex_val};
                end else if (rx_sh == `CGM_CHR_LF && p_cr && p_cmd != 8'h00 && !ser_pend
                             && tx_idle) begin
                    ser_pend <= 1'b1;
                    s_wr <= (p_cmd == `CGM_CHR_WR);
                    s_addr <= (p_cmd == `CGM_CHR_WR) ? p_acc[23:16] : p_acc[7:0];
                    s_data <= p_acc[15:0];
                    p_cmd <= 8'h00;
                end
            end
        end
    end

    // Shared register access, port first, serial in idle cycles
    wire [7:0] eff_addr = ser_go ? s_addr : addr_in;
    wire [15:0] eff_wdata = ser_go ? s_data : wdata_in;
    wire eff_wr = wr_in | (ser_go & s_wr);
    wire eff_rd = rd_in | (ser_go & ~s_wr);
    wire [4:0] ch_idx = 5'(eff_addr[7:3] - 5'h02);
    wire ch_ok = (eff_addr >= `CGM_CH_BASE) && (ch_idx < 5'(NCH));
    wire [CW-1:0] ch_sel = ch_idx[CW-1:0];
    wire [2:0] fld = eff_addr[2:0];
    wire ctrl_wr = eff_wr && (eff_addr == `CGM_REG_CTRL);
    wire fld_wr = eff_wr && ch_ok;
    wire save_go = (ctrl_wr && eff_wdata[`CGM_CTRL_SAVE]) || pd_rise;
    wire dflt_go = (ctrl_wr && eff_wdata[`CGM_CTRL_DEFAULT]) || fr_rise;
    wire rd_status = eff_rd && (eff_addr == `CGM_REG_STATUS);
    wire rd_chstat = eff_rd && ch_ok && (fld == `CGM_CH_STAT);
    cgm_chan_t sel_c;
    assign sel_c = ch[ch_sel];
    wire [7:0] exc_clamp = (eff_wdata[7:0] > `CGM_EXC_MAX) ? `CGM_EXC_MAX : eff_wdata[7:0];
    wire [15:0] ch_val =
        (fld == `CGM_CH_GAIN) ? {8'h00, sel_c.gain} :
        (fld == `CGM_CH_EXC) ? {7'h00, sel_c.exc_on, sel_c.exc_level} :
        (fld == `CGM_CH_SENSOR_SENSITIVITY) ? sel_c.sensor_sensitivity :
        (fld == `CGM_CH_FULL_SCALE_INPUT_VALUE) ? sel_c.full_scale_input_value :
        (fld == `CGM_CH_LEVEL) ? {15'h0000, sel_c.full_scale_output_level} :
        (fld == `CGM_CH_NORM) ? norm[ch_sel] :
        (fld == `CGM_CH_STAT) ? {12'h000, gerr[ch_sel], open_f[ch_sel], short_f[ch_sel],
                                 ovl_latch[ch_sel]} : 16'h0000;
    wire [15:0] status_val = {as_state != AS_IDLE, 15'(ovl_latch)};
    wire [15:0] rd_val = (eff_addr == `CGM_REG_CTRL) ? {14'h0000, mode} :
                         (eff_addr == `CGM_REG_STATUS) ? status_val :
                         ch_ok ? ch_val : 16'h0000;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) rdata_out <= 16'h0000;
        else rdata_out <= rd_in ? rd_val : 16'h0000;
    end

    // Serial transmitter, answers end with CR LF
    logic [47:0] tx_buf;
    logic [9:0] tx_shift;
    logic [15:0] tx_cnt;
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            tx_buf <= 48'h000000000000;
            tx_chars <= 3'h0;
            tx_bit <= 4'h0;
            tx_shift <= 10'h3ff;
            tx_cnt <= 16'h0000;
            tx_out <= 1'b1;
        end else begin
            tx_out <= (tx_bit != 4'h0) ? tx_shift[0] : 1'b1;
            if (ser_go) begin
                tx_chars <= s_wr ? 3'h2 : 3'h6;
                tx_buf <= s_wr ? {`CGM_CHR_CR, `CGM_CHR_LF, 32'h00000000} :
                          {cgm_hex_chr(rd_val[15:12]), cgm_hex_chr(rd_val[11:8]),
                           cgm_hex_chr(rd_val[7:4]), cgm_hex_chr(rd_val[3:0]),
                           `CGM_CHR_CR, `CGM_CHR_LF};
            end else if (tx_bit == 4'h0 && tx_chars != 3'h0) begin
                tx_shift <= {1'b1, tx_buf[47:40], 1'b0};
                tx_buf <= {tx_buf[39:0], 8'h00};
                tx_chars <= tx_chars - 3'h1;
                tx_bit <= 4'ha;
                tx_cnt <= 16'(BIT_CYCLES - 1);
            end else if (tx_bit != 4'h0) begin
                if (tx_cnt == 16'h0000) begin
                    tx_shift <= {1'b1, tx_shift[9:1]};
                    tx_bit <= tx_bit - 4'h1;
                    tx_cnt <= 16'(BIT_CYCLES - 1);
                end else begin
                    tx_cnt <= tx_cnt - 16'h0001;
                end
            end
        end
    end

    // Fault window and overload latch
    logic [NCH-1:0] short_w, open_w, ovl_clr;
    for (genvar g = 0; g < NCH; g++) begin : g_win
        assign short_w[g] = bias_mv_in[g*16 +: 16] < `CGM_SHORT_MV;
        assign open_w[g] = bias_mv_in[g*16 +: 16] > `CGM_OPEN_MV;
        assign ovl_clr[g] = rd_status || (rd_chstat && ch_sel == CW'(g));
    end
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            short_f <= '0;
            open_f <= '0;
            ovl_latch <= '0;
        end else begin
            short_f <= short_w;
            open_f <= open_w;
            ovl_latch <= (ovl_latch & ~ovl_clr) | ovl_now;
        end
    end

    // Automatic gain scaling
    wire as_run = (mode == MODE_ON) || (mode == MODE_SINGLE);
    wire single_done = (as_state == AS_CHECK) && (seen == '0) && (mode == MODE_SINGLE);
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            mode <= MODE_OFF;
        end else if (ctrl_wr) begin
            mode <= cgm_scale_mode_t'(eff_wdata[1:0]);
        end else if (single_done || dflt_go) begin
            mode <= MODE_OFF;
        end
    end
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            as_state <= AS_IDLE;
            as_cnt <= 32'h00000000;
            seen <= '0;
        end else begin
            case (as_state)
                AS_IDLE: if (as_run) as_state <= AS_MAX;
                AS_MAX: begin
                    as_cnt <= 32'(SETTLE_CYCLES - 1);
                    seen <= '0;
                    as_state <= AS_SETTLE;
                end
                AS_SETTLE: begin
                    seen <= seen | ovl_now;
                    if (!as_run) as_state <= AS_IDLE;
                    else if (as_cnt == 32'h00000000) as_state <= AS_CHECK;
                    else as_cnt <= as_cnt - 32'h00000001;
                end
                AS_CHECK: begin
                    as_cnt <= 32'(SETTLE_CYCLES - 1);
                    seen <= '0;
                    as_state <= (single_done || !as_run) ? AS_IDLE : AS_SETTLE;
                end
                default: as_state <= AS_IDLE;
            endcase
        end
    end

    // Channel settings, live copy
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            for (int i = 0; i < NCH; i++) ch[i] <= CH_DEF;
        end else if (restore_pend && nv_ok) begin
            ch <= nv;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (dflt_go) begin
                    ch[i] <= CH_DEF;
                end else begin
                    if (as_state == AS_MAX) ch[i].gain <= `CGM_GAIN_TOP;
                    else if (as_state == AS_CHECK && seen[i] && ch[i].gain != 8'h00)
                        ch[i].gain <= ch[i].gain - 8'h01;
                    else if (fld_wr && ch_sel == CW'(i) && fld == `CGM_CH_GAIN)
                        ch[i].gain <= eff_wdata[7:0];
                    if (fld_wr && ch_sel == CW'(i)) begin
                        if (fld == `CGM_CH_EXC) begin
                            ch[i].exc_level <= exc_clamp;
                            ch[i].exc_on <= eff_wdata[`CGM_EXC_ON_BIT];
                        end
                        if (fld == `CGM_CH_SENSOR_SENSITIVITY) ch[i].sensor_sensitivity <= eff_wdata;
                        if (fld == `CGM_CH_FULL_SCALE_INPUT_VALUE) ch[i].full_scale_input_value <= eff_wdata;
                        if (fld == `CGM_CH_LEVEL) ch[i].full_scale_output_level <= eff_wdata[0];
                    end
                end
            end
        end
    end

    // Non-volatile copy, kept across reset
    always_ff @(posedge clk_in) begin
        if (dflt_go) for (int i = 0; i < NCH; i++) nv[i] <= CH_DEF;
        else if (save_go) nv <= ch;
    end
    // Blank store keeps factory values at first power-up
    always_ff @(posedge clk_in) begin
        if (dflt_go || save_go) nv_ok <= 1'b1;
    end
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) restore_pend <= 1'b1;
        else restore_pend <= 1'b0;
    end

    // Normalised gain, shared restoring divider
    logic [CW-1:0] dv_ch;
    logic [5:0] dv_step;
    logic [31:0] dv_rem, dv_quo, dv_den;
    cgm_chan_t dv_c;
    assign dv_c = ch[dv_ch];
    wire [31:0] dv_prod = dv_c.sensor_sensitivity * dv_c.full_scale_input_value;
    wire [15:0] dv_num = dv_c.full_scale_output_level ? `CGM_LEVEL_5V : `CGM_LEVEL_1V;
    wire [32:0] dv_trial = {dv_rem, dv_quo[31]} - {1'b0, dv_den};
    wire dv_bad = (dv_den == 32'h00000000) || (dv_quo > 32'(GAIN_MAX))
                  || (dv_quo < 32'(GAIN_MIN));
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            dv_ch <= '0;
            dv_step <= 6'h00;
            dv_rem <= 32'h00000000;
            dv_quo <= 32'h00000000;
            dv_den <= 32'h00000000;
            gerr <= '0;
            for (int i = 0; i < NCH; i++) norm[i] <= 16'h0000;
        end else if (dv_step == 6'h00) begin
            dv_rem <= 32'h00000000;
            dv_quo <= {16'h0000, dv_num};
            dv_den <= dv_prod;
            dv_step <= 6'h01;
        end else if (dv_step == 6'h21) begin
            norm[dv_ch] <= (dv_quo > 32'h0000ffff) ? 16'hffff : dv_quo[15:0];
            gerr[dv_ch] <= dv_bad;
            dv_ch <= (dv_ch == CW'(NCH - 1)) ? '0 : CW'(dv_ch + 1'b1);
            dv_step <= 6'h00;
        end else begin
            dv_rem <= dv_trial[32] ? {dv_rem[30:0], dv_quo[31]} : dv_trial[31:0];
            dv_quo <= {dv_quo[30:0], ~dv_trial[32]};
            dv_step <= dv_step + 6'h01;
        end
    end

    // Registered outputs
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            gain_out <= '0;
            exc_level_out <= '0;
            exc_on_out <= '0;
            fault_led_out <= '0;
            ovl_led_out <= '0;
            scaling_active_out <= 1'b0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                gain_out[i*8 +: 8] <= ch[i].gain;
                exc_level_out[i*8 +: 8] <= ch[i].exc_on ? ch[i].exc_level : 8'h00;
                exc_on_out[i] <= ch[i].exc_on;
            end
            fault_led_out <= short_w | open_w;
            ovl_led_out <= ovl_now;
            scaling_active_out <= (as_state != AS_IDLE);
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    for (genvar g = 0; g < NCH; g++) begin : g_chk
        a_short_class: assert property (
            bias_mv_in[g*16 +: 16] < 16'h07d0 |=> short_f[g] && fault_led_out[g])
            else $error("short bias not flagged");
        a_open_class: assert property (
            bias_mv_in[g*16 +: 16] > 16'h55f0 |=> open_f[g] && fault_led_out[g])
            else $error("open bias not flagged");
        a_exc_gate: assert property (
            !ch[g].exc_on |=> !exc_on_out[g] && exc_level_out[g*8 +: 8] == 8'h00)
            else $error("excitation present while switched off");
        a_exc_limit: assert property (
            exc_level_out[g*8 +: 8] <= 8'hc8)
            else $error("excitation above limit");
        a_ovl_set: assert property (
            ovl_now[g] |=> ovl_latch[g] && ovl_led_out[g])
            else $error("overload not captured");
        a_ovl_hold: assert property (
            ovl_latch[g] && !ovl_clr[g] |=> ovl_latch[g])
            else $error("overload latch lost");
        a_ovl_clear: assert property (
            ovl_clr[g] && !ovl_now[g] |=> !ovl_latch[g])
            else $error("latch not cleared by read");
        a_scale_max: assert property (
            as_state == AS_MAX && !dflt_go |=> ch[g].gain == 8'hff)
            else $error("scaling did not set maximum gain");
        a_scale_step: assert property (
            as_state == AS_CHECK && seen[g] && ch[g].gain != 8'h00 && !dflt_go
            |=> ch[g].gain == $past(ch[g].gain) - 8'h01)
            else $error("overloaded gain not lowered");
    end
    a_single_off: assert property (
        single_done && !ctrl_wr |=> mode == MODE_OFF ##1 as_state == AS_IDLE)
        else $error("single shot did not switch off");
    c_scale_drop: cover property (as_state == AS_CHECK && seen != '0);
    c_single_end: cover property (single_done);
    c_line_end: cover property (rx_stb && rx_sh == `CGM_CHR_LF && p_cr);
    c_ovl_read: cover property (rd_status && ovl_latch != '0);
endmodule // cgm_monitor

// file: verif/cgm_host_model.sv
// Purpose: Host computer on the serial link
// Assumes: 8N1, LSB first, line idles high
// Notes: Sends bytes and collects answer bytes
`timescale 1ns/1ps
module cgm_host_model #(
    parameter int BIT = 8
) (
    input wire logic clk_in,
    input wire logic tx_in,
    output logic rx_out
);
    initial rx_out = 1'b1;
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_out <= f[i];
            repeat (BIT) @(posedge clk_in);
        end
    endtask
    task automatic get(output logic [7:0] b);
        @(negedge tx_in);
        repeat (BIT / 2 + BIT) @(posedge clk_in);
        for (int i = 0; i < 8; i++) begin
            b[i] = tx_in;
            repeat (BIT) @(posedge clk_in);
        end
    endtask
endmodule // cgm_host_model

// file: verif/tb_top.sv
// Purpose: Self-checking bench of the gain and overload monitor
// Assumes: Short bit and settle counts
// Notes: Register tasks, serial through host model
`timescale 1ns/1ps
module tb_top;
    logic clk_in = 1'b0, reset_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, pd = 1'b0, fr = 1'b0;
    logic rx, tx, act;
    logic [7:0] wl[9] = '{8'h57, 8'h31, 8'h30, 8'h30, 8'h30, 8'h34, 8'h34, 8'h0d, 8'h0a};
    logic [7:0] addr_in = 8'h00, b;
    logic [15:0] wdata_in = 16'h0000, rdata_out;
    logic [63:0] bias = {4{16'h1388}};
    logic [3:0] cmp_n = 4'hf, exc_on, fault, ovl;
    logic [31:0] gain, exc;
    logic [15:0] bv[4] = '{16'd1999, 16'd2000, 16'd22000, 16'd22001};
    logic [15:0] se[4] = '{16'h2, 16'h0, 16'h0, 16'h4};
    logic [7:0] cmd[5] = '{8'h52, 8'h31, 8'h30, 8'h0d, 8'h0a};
    logic [7:0] ans[6] = '{8'h30, 8'h30, 8'h33, 8'h33, 8'h0d, 8'h0a};
    int n_errors = 0, n_checks = 0, cyc = 0;
    always #4 clk_in = ~clk_in;
    cgm_monitor #(.NCH(4), .BIT_CYCLES(8), .SETTLE_CYCLES(20)) i_cgm_monitor (
        .clk_in, .reset_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
        .bias_mv_in(bias), .ovl_cmp_n_in(cmp_n), .power_down_in(pd),
        .factory_reset_in(fr), .rx_in(rx), .tx_out(tx), .gain_out(gain),
        .exc_level_out(exc), .exc_on_out(exc_on), .fault_led_out(fault),
        .ovl_led_out(ovl), .scaling_active_out(act));
    cgm_host_model #(.BIT(8)) i_cgm_host_model (.clk_in, .tx_in(tx), .rx_out(rx));
    task automatic chk(input string n, input logic [15:0] e, g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk("rdata", e, rdata_out);
    endtask
    task automatic rst();
        reset_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        repeat (4) @(posedge clk_in);
        reset_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        wr(8'h00, 16'h0008);
        rd(8'h10, 16'h0001);
        rd(8'h11, 16'h0128);
        rd(8'h0f, 16'h0000);
        wr(8'h11, 16'h01ff);
        rd(8'h11, 16'h01c8);
        chk("exc0", 16'h00c8, {8'h00, exc[7:0]});
        chk("exc_on0", 16'h0001, {15'h0, exc_on[0]});
        wr(8'h11, 16'h0033);
        repeat (2) @(posedge clk_in);
        #1 chk("exc0", 16'h0000, {8'h00, exc[7:0]});
        chk("exc_on0", 16'h0000, {15'h0, exc_on[0]});
        $display("excitation test done");
        foreach (bv[i]) begin
            bias[63:48] <= bv[i];
            repeat (3) @(posedge clk_in);
            #1 chk("fault3", {15'h0, se[i] != 0}, {15'h0, fault[3]});
            rd(8'h2e, se[i]);
        end
        $display("fault test done");
        wr(8'h12, 16'h000a);
        wr(8'h13, 16'h000a);
        wr(8'h14, 16'h0001);
        wr(8'h1a, 16'h03e8);
        wr(8'h1b, 16'h0064);
        repeat (200) @(posedge clk_in);
        rd(8'h15, 16'h0032);
        rd(8'h16, 16'h0000);
        rd(8'h1e, 16'h0008);
        wr(8'h14, 16'h0000);
        wr(8'h12, 16'h0001);
        wr(8'h13, 16'h0001);
        repeat (200) @(posedge clk_in);
        rd(8'h15, 16'h03e8);
        rd(8'h16, 16'h0008);
        $display("gain test done");
        cmp_n <= 4'hd;
        repeat (4) @(posedge clk_in);
        #1 chk("ovl", 16'h0002, {12'h0, ovl});
        cmp_n <= 4'hf;
        repeat (3) @(posedge clk_in);
        rd(8'h01, 16'h0002);
        rd(8'h01, 16'h0000);
        wr(8'h00, 16'h0001);
        repeat (60) @(posedge clk_in);
        #1 chk("act", 16'h0001, {15'h0, act});
        chk("gain0", 16'h00ff, {8'h00, gain[7:0]});
        wr(8'h00, 16'h0000);
        repeat (4) @(posedge clk_in);
        #1 chk("act", 16'h0000, {15'h0, act});
        wr(8'h00, 16'h0002);
        repeat (3) @(posedge clk_in);
        cmp_n <= 4'hb;
        repeat (3) @(posedge clk_in);
        cmp_n <= 4'hf;
        for (int i = 0; i < 500 && act !== 1'b0; i++) @(posedge clk_in);
        #1 chk("gain2", 16'h00fe, {8'h00, gain[23:16]});
        rd(8'h01, 16'h0004);
        rd(8'h00, 16'h0000);
        $display("overload and scaling test done");
        wr(8'h10, 16'h0033);
        pd <= 1'b1;
        repeat (5) @(posedge clk_in);
        pd <= 1'b0;
        rst();
        #1 chk("gain0", 16'h0033, {8'h00, gain[7:0]});
        rd(8'h11, 16'h0033);
        fork
            foreach (cmd[i]) i_cgm_host_model.send(cmd[i]);
            for (int i = 0; i < 6; i++) begin
                i_cgm_host_model.get(b);
                chk("tx", {8'h00, ans[i]}, {8'h00, b});
            end
        join
        fork
            foreach (wl[i]) i_cgm_host_model.send(wl[i]);
            for (int i = 4; i < 6; i++) begin
                i_cgm_host_model.get(b);
                chk("tx", {8'h00, ans[i]}, {8'h00, b});
            end
        join
        rd(8'h10, 16'h0044);
        wr(8'h00, 16'h0004);
        rst();
        #1 chk("gain0", 16'h0044, {8'h00, gain[7:0]});
        fr <= 1'b1;
        repeat (4) @(posedge clk_in);
        fr <= 1'b0;
        rd(8'h10, 16'h0001);
        rst();
        rd(8'h10, 16'h0001);
        $display("restore and serial test done");
        end_of_test();
    end
endmodule // tb_top
